// File: pkg/irqm_pkg.sv
// Constants, types and register layout for the serial register port with interrupt mask
package irqm_pkg;

   // ==========================================================
   // Target addresses (7-bit) for the two variants
   localparam logic [6:0] ADDR_VARIANT_A = 7'h35;
   localparam logic [6:0] ADDR_VARIANT_B = 7'h15;

   // ==========================================================
   // Register map
   localparam logic [7:0] OFF_FIRST      = 8'h00;
   localparam logic [7:0] OFF_LAST       = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h08;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   localparam logic [7:0] READ_FILL      = 8'h00;

   // ==========================================================
   // Mask bit positions
   localparam int BIT_PORT_DEVICE_DETECT = 7;
   localparam int BIT_HANDSHAKE_SKIP     = 6;
   localparam int BIT_CONNECT_CHECK      = 5;
   localparam int BIT_RESERVED           = 4;
   localparam int BIT_DATA_SESSION       = 3;
   localparam int BIT_REMOTE_WAKE        = 2;
   localparam int BIT_SUPPLY_TOGGLE_BEG  = 1;
   localparam int BIT_SUPPLY_TOGGLE_END  = 0;
   localparam logic [7:0] MASK_WRITABLE  = 8'hef;

   // ==========================================================
   // Serial framing
   localparam logic [3:0] BIT_LAST_DATA  = 4'h7;
   localparam logic [3:0] BIT_ACK_SLOT   = 4'h8;
   localparam logic [3:0] BIT_AFTER_FIRST = 4'h1;
   localparam logic       DIR_READ       = 1'b1;

   // ==========================================================
   // Link timing
   localparam int LINK_FMAX_KHZ = 400;
   localparam int SYS_CLK_KHZ   = 25000;
   localparam int SAMPLES_PER_HALF_BIT = SYS_CLK_KHZ / (2 * LINK_FMAX_KHZ);

   typedef enum logic [2:0] {
      LS_IDLE  = 3'b000,
      LS_ADDR  = 3'b001,
      LS_OFFS  = 3'b010,
      LS_WDATA = 3'b011,
      LS_RDATA = 3'b100
   } irqm_link_state_t;

   typedef struct packed {
      logic [7:0] offset;
      logic [7:0] data;
   } irqm_wr_req_t;

endpackage : irqm_pkg

// File: design/irqm_regport.sv
// Serial register port target holding the interrupt mask register
//
// Functional notes
// - Mask register at 0x08, resets zero
// - Mask bit one lets event set flag
// - Mask bit positions fixed as listed
// - Serial clock up to 400kHz supported
// - Fixed target address, chosen per variant
// - Sample data on rising clock edges
// - Idle bus: both lines released high
// - Single write: address, offset, data acknowledged
// - Acknowledge only valid register offsets
// - Offset auto-increments except at 0x00
// - Burst write: every data byte acknowledged
// - Single read: offset, restart, one byte
// - Burst read: successive bytes until NACK
`timescale 1ns/1ps
`default_nettype none

module irqm_regport #(
   parameter bit VARIANT_B = 1'b0               // Selects the alternate target address
) (
   input  wire logic                  i_clk_sys,    // System clock, 25 MHz
   input  wire logic                  i_rst,        // Asynchronous reset, active high
   input  wire logic                  i_scl,        // Serial clock from master, link clock
   input  wire logic                  i_sda,        // Serial data line level
   output logic                       o_sda_out,    // Serial data drive value
   output logic                       o_sda_oe,     // Serial data drive enable
   input  wire logic [7:0]            i_status,     // Event status bits, system domain
   output logic      [7:0]            o_flag_set,   // Flag set pulses to interrupt register
   output logic      [7:0]            o_mask,       // Current interrupt mask
   output logic                       o_wr_valid,   // One-cycle pulse, other register write
   output irqm_pkg::irqm_wr_req_t     o_wr_req,     // Offset and data of that write
   output logic                       o_bus_busy    // Bus between START and STOP
);

   localparam logic [6:0] TGT_ADDR =
      VARIANT_B ? irqm_pkg::ADDR_VARIANT_B : irqm_pkg::ADDR_VARIANT_A;

   // ==========================================================
   // System-domain pin synchronisers and condition detection
   logic scl_s1_q, scl_s2_q, scl_s3_q;
   logic sda_s1_q, sda_s2_q, sda_s3_q;
   logic start_tog_q;
   logic bus_busy_q;
   logic start_det, stop_det;

   // Sys clock oversamples the fastest legal link clock many times over

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
      end else begin
         scl_s1_q <= i_scl;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= i_sda;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
      end
   end

   // Data change while the clock is high marks START or STOP
   assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   assign stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         start_tog_q <= 1'b0;
         bus_busy_q  <= 1'b0;
      end else begin
         if (start_det) begin
            start_tog_q <= ~start_tog_q;
            bus_busy_q  <= 1'b1;
         end else if (stop_det) begin
            bus_busy_q  <= 1'b0;
         end
      end
   end

   assign o_bus_busy = bus_busy_q;

   // ==========================================================
   // Link domain: START toggle crossing over the two clock edges
   // The toggle settles long before the falling edge after START, so
   // the falling-edge flop feeds the rising-edge flop as a two-stage sync.
   logic start_ls1_q, start_ls2_q, start_seen_q;
   logic [7:0] mask_ls1_q, mask_ls2_q;
   logic [7:0] mask_q;

   always_ff @(negedge i_scl or posedge i_rst) begin
      if (i_rst) begin
         start_ls1_q <= 1'b0;
         mask_ls1_q  <= irqm_pkg::IRQ_MASK_RESET;
         mask_ls2_q  <= irqm_pkg::IRQ_MASK_RESET;
      end else begin
         start_ls1_q <= start_tog_q;
         // Mask only changes from this link, so it is quiet at sampling
         mask_ls1_q  <= mask_q;
         mask_ls2_q  <= mask_ls1_q;
      end
   end

   always_ff @(posedge i_scl or posedge i_rst) begin
      if (i_rst) begin
         start_ls2_q <= 1'b0;
      end else begin
         start_ls2_q <= start_ls1_q;
      end
   end

   // ==========================================================
   // Link domain: byte engine, sampled on rising clock edges
   irqm_pkg::irqm_link_state_t state_q;
   logic [3:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] off_q;
   logic       ack_q;
   logic       wr_tog_q;
   irqm_pkg::irqm_wr_req_t wr_hold_q;
   logic [7:0] rx_byte;
   logic [7:0] rd_byte;
   logic [7:0] off_next;
   logic       new_frame;
   logic       first_bit_q;

   localparam logic [3:0] BITS_AT_SYNC = irqm_pkg::BIT_AFTER_FIRST + 4'h1;

   assign new_frame = start_ls2_q ^ start_seen_q;
   assign rx_byte   = {shift_q, i_sda};
   assign rd_byte   = (off_q == irqm_pkg::OFF_IRQ_MASK) ? mask_ls2_q : irqm_pkg::READ_FILL;
   // Offset 0x00 never advances
   assign off_next  = (off_q == irqm_pkg::OFF_FIRST) ? off_q : off_q + 8'h01;

   // Keeps the bit sampled before the crossed START becomes visible
   always_ff @(posedge i_scl or posedge i_rst) begin
      if (i_rst) begin
         first_bit_q <= 1'b1;
      end else begin
         first_bit_q <= i_sda;
      end
   end

   always_ff @(posedge i_scl or posedge i_rst) begin
      if (i_rst) begin
         state_q      <= irqm_pkg::LS_IDLE;
         bit_cnt_q    <= 4'h0;
         shift_q      <= 7'h00;
         tx_q         <= 8'h00;
         off_q        <= irqm_pkg::OFF_FIRST;
         ack_q        <= 1'b0;
         wr_tog_q     <= 1'b0;
         wr_hold_q    <= '0;
         start_seen_q <= 1'b0;
      end else if (new_frame) begin
         // START shows at the second address bit; the first waits in first_bit_q
         start_seen_q <= start_ls2_q;
         state_q      <= irqm_pkg::LS_ADDR;
         shift_q      <= {5'h00, first_bit_q, i_sda};
         bit_cnt_q    <= BITS_AT_SYNC;
         ack_q        <= 1'b0;
      end else begin
         case (state_q)
            irqm_pkg::LS_ADDR, irqm_pkg::LS_OFFS, irqm_pkg::LS_WDATA: begin
               if (bit_cnt_q < irqm_pkg::BIT_LAST_DATA) begin
                  shift_q   <= rx_byte[6:0];
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (bit_cnt_q == irqm_pkg::BIT_LAST_DATA) begin
                  bit_cnt_q <= irqm_pkg::BIT_ACK_SLOT;
                  if (state_q == irqm_pkg::LS_ADDR) begin
                     ack_q <= (rx_byte[7:1] == TGT_ADDR);
                     shift_q <= {6'h00, rx_byte[0]};
                  end else if (state_q == irqm_pkg::LS_OFFS) begin
                     ack_q <= (rx_byte <= irqm_pkg::OFF_LAST);
                     off_q <= rx_byte;
                  end else begin
                     ack_q     <= 1'b1;
                     wr_hold_q <= '{offset: off_q, data: rx_byte};
                     wr_tog_q  <= ~wr_tog_q;
                     off_q     <= off_next;
                  end
               end else begin
                  bit_cnt_q <= 4'h0;
                  if (!ack_q) begin
                     state_q <= irqm_pkg::LS_IDLE;
                  end else if (state_q == irqm_pkg::LS_ADDR) begin
                     if (shift_q[0] == irqm_pkg::DIR_READ) begin
                        state_q <= irqm_pkg::LS_RDATA;
                        tx_q    <= rd_byte;
                        off_q   <= off_next;
                     end else begin
                        state_q <= irqm_pkg::LS_OFFS;
                     end
                  end else begin
                     state_q <= irqm_pkg::LS_WDATA;
                  end
               end
            end
            irqm_pkg::LS_RDATA: begin
               if (bit_cnt_q < irqm_pkg::BIT_ACK_SLOT) begin
                  tx_q      <= {tx_q[6:0], 1'b0};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else begin
                  bit_cnt_q <= 4'h0;
                  if (i_sda) begin
                     state_q <= irqm_pkg::LS_IDLE;
                  end else begin
                     tx_q  <= rd_byte;
                     off_q <= off_next;
                  end
               end
            end
            default: begin
               bit_cnt_q <= 4'h0;
            end
         endcase
      end
   end

   // ==========================================================
   // Link domain: data drive, changed on falling clock edges
   logic sda_oe_q;

   always_ff @(negedge i_scl or posedge i_rst) begin
      if (i_rst) begin
         sda_oe_q <= 1'b0;
      end else begin
         if (state_q == irqm_pkg::LS_RDATA) begin
            // Released in the acknowledge slot so the master can answer
            sda_oe_q <= (bit_cnt_q < irqm_pkg::BIT_ACK_SLOT) & ~tx_q[7];
         end else if (state_q != irqm_pkg::LS_IDLE) begin
            sda_oe_q <= (bit_cnt_q == irqm_pkg::BIT_ACK_SLOT) & ack_q;
         end else begin
            sda_oe_q <= 1'b0;
         end
      end
   end

   assign o_sda_oe  = sda_oe_q;
   assign o_sda_out = 1'b0;

   // ==========================================================
   // System domain: write handshake and mask register
   logic wr_s1_q, wr_s2_q, wr_s3_q;
   logic wr_valid_q;
   irqm_pkg::irqm_wr_req_t wr_req_q;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wr_s1_q <= 1'b0;
         wr_s2_q <= 1'b0;
         wr_s3_q <= 1'b0;
      end else begin
         wr_s1_q <= wr_tog_q;
         wr_s2_q <= wr_s1_q;
         wr_s3_q <= wr_s2_q;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mask_q     <= irqm_pkg::IRQ_MASK_RESET;
         wr_valid_q <= 1'b0;
         wr_req_q   <= '0;
      end else begin
         wr_valid_q <= 1'b0;
         if (wr_s2_q ^ wr_s3_q) begin
            if (wr_hold_q.offset == irqm_pkg::OFF_IRQ_MASK) begin
               // Reserved position is held at zero
               mask_q <= wr_hold_q.data & irqm_pkg::MASK_WRITABLE;
            end else if (wr_hold_q.offset <= irqm_pkg::OFF_LAST) begin
               wr_valid_q <= 1'b1;
               wr_req_q   <= wr_hold_q;
            end
         end
      end
   end

   assign o_mask     = mask_q;
   assign o_wr_valid = wr_valid_q;
   assign o_wr_req   = wr_req_q;

   // ==========================================================
   // System domain: event gating toward the interrupt flags
   logic [7:0] status_prev_q;
   logic [7:0] flag_set_q;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         status_prev_q <= 8'h00;
         flag_set_q    <= 8'h00;
      end else begin
         status_prev_q <= i_status;
         // A flag is set only when its status rises and its mask bit is one
         flag_set_q    <= i_status & ~status_prev_q & mask_q
                          & irqm_pkg::MASK_WRITABLE;
      end
   end

   assign o_flag_set = flag_set_q;

endmodule : irqm_regport

`default_nettype wire

// File: verif/irqm_checker.sv
// Concurrent checks on the register port outputs
`timescale 1ns/1ps
`default_nettype none
module irqm_checker (
   input wire logic                   i_clk_sys,  // System clock
   input wire logic                   i_rst,      // Reset, active high
   input wire logic                   i_scl,      // Serial clock
   input wire logic [7:0]             i_status,   // Event status
   input wire logic                   o_sda_oe,   // Data pull enable
   input wire logic [7:0]             o_flag_set, // Flag pulses
   input wire logic [7:0]             o_mask,     // Mask value
   input wire logic                   o_wr_valid, // Write pulse
   input wire irqm_pkg::irqm_wr_req_t o_wr_req,   // Write request
   input wire logic                   o_bus_busy  // Bus busy
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // ==========================================
   // Assertions
   sequence s_wr_pulse;
      o_wr_valid ##1 !o_wr_valid;
   endsequence
   a_mask_rsv_zero: assert property (o_mask[4] == 1'b0)
      else $error("reserved mask bit set");
   a_flag_gated: assert property ((o_flag_set & ~$past(o_mask)) == 8'h00)
      else $error("flag set while masked");
   a_flag_rise: assert property ((o_flag_set & ($past(i_status, 2) | ~$past(i_status))) == 8'h00)
      else $error("flag without status rise");
   a_flag_pulse: assert property ((o_flag_set & $past(o_flag_set)) == 8'h00)
      else $error("flag pulse too long");
   a_wr_pulse: assert property (o_wr_valid |-> s_wr_pulse)
      else $error("write pulse too long");
   a_wr_range: assert property (o_wr_valid |-> o_wr_req.offset < 8'h08)
      else $error("write to bad offset");
   a_wr_in_busy: assert property (o_wr_valid |-> o_bus_busy)
      else $error("write outside transfer");
   a_idle_release: assert property (!o_bus_busy |-> !o_sda_oe)
      else $error("data driven while idle");
   a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data changed with clock high");
   a_mask_in_busy: assert property ($changed(o_mask) |-> o_bus_busy)
      else $error("mask changed outside transfer");
endmodule : irqm_checker
bind irqm_regport irqm_checker u_irqm_checker (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_scl(i_scl), .i_status(i_status), .o_sda_oe(o_sda_oe), .o_flag_set(o_flag_set),
   .o_mask(o_mask), .o_wr_valid(o_wr_valid), .o_wr_req(o_wr_req), .o_bus_busy(o_bus_busy));
`default_nettype wire

// File: verif/irqm_master.sv
// Serial bus master model driving clock and data
`timescale 1ns/1ps
`default_nettype none
module irqm_master #(
   parameter int HALF = 32                   // Sys cycles per half bit, below 400kHz
) (
   input  wire logic i_clk_sys,              // Pacing clock
   input  wire logic i_sda,                  // Resolved data wire
   output logic      o_scl,                  // Serial clock, idle high
   output logic      o_sda_low               // High pulls data low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic hp;
      repeat (HALF) @(posedge i_clk_sys);
      #1;
   endtask : hp
   // Data set while clock low, sampled at end of high phase
   task automatic bit_io(input logic b, output logic r);
      o_sda_low = !b;
      hp();
      o_scl = 1'b1;
      hp();
      r = i_sda;
      o_scl = 1'b0;
   endtask : bit_io
   // Start or repeated start
   task automatic start;
      o_sda_low = 1'b0;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_low = 1'b1;
      hp();
      o_scl = 1'b0;
   endtask : start
   task automatic stop;
      o_sda_low = 1'b1;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_low = 1'b0;
      hp();
   endtask : stop
   // MSB first, ninth clock carries the acknowledge
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : wbyte
   task automatic rbyte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(!more, r);
   endtask : rbyte
endmodule : irqm_master
`default_nettype wire

// File: verif/irqm_regport_tb_top.sv
// Self-checking bench for the register port with interrupt mask
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module irqm_regport_tb_top;
   logic                   clk = 1'b0;
   logic                   rst = 1'b0;
   logic                   scl;
   logic                   m_low;
   logic [7:0]             status = 8'h00;
   logic                   oe, sda_out, wr_valid, busy;
   logic [7:0]             flag, mask, fl_acc;
   irqm_pkg::irqm_wr_req_t wr_req;
   irqm_pkg::irqm_wr_req_t wq[$];
   wire                    sda = !(m_low | oe);
   int                     mismatches = 0;
   int                     samples_checked = 0;
   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (wr_valid) wq.push_back(wr_req);
      fl_acc <= fl_acc | flag;
   end
   irqm_regport u_irqm_regport (.i_clk_sys(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe(oe), .i_status(status), .o_flag_set(flag),
      .o_mask(mask), .o_wr_valid(wr_valid), .o_wr_req(wr_req), .o_bus_busy(busy));
   irqm_master u_irqm_master (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
   // ==========================================
   // Transfer tasks
   task automatic wr(input logic [7:0] off, input logic [7:0] d[$], input logic ok);
      logic a;
      u_irqm_master.start();
      u_irqm_master.wbyte({irqm_pkg::ADDR_VARIANT_A, 1'b0}, a);
      `CHK("addr ack", 1'b1, a)
      u_irqm_master.wbyte(off, a);
      `CHK("offset ack", ok, a)
      foreach (d[i]) begin
         u_irqm_master.wbyte(d[i], a);
         `CHK("data ack", ok, a)
      end
      u_irqm_master.stop();
   endtask : wr
   task automatic rd(input logic [7:0] off, input logic [7:0] e[$]);
      logic a;
      logic [7:0] d;
      u_irqm_master.start();
      u_irqm_master.wbyte({irqm_pkg::ADDR_VARIANT_A, 1'b0}, a);
      u_irqm_master.wbyte(off, a);
      u_irqm_master.start();
      u_irqm_master.wbyte({irqm_pkg::ADDR_VARIANT_A, 1'b1}, a);
      `CHK("read addr ack", 1'b1, a)
      foreach (e[i]) begin
         u_irqm_master.rbyte(i < e.size() - 1, d);
         `CHK("read data", e[i], d)
      end
      u_irqm_master.stop();
   endtask : rd
   // ==========================================
   // Scenarios
   task automatic t_reset;
      `CHK("mask reset", 8'h00, mask)
      `CHK("busy reset", 1'b0, busy)
      `CHK("oe reset", 1'b0, oe)
      `CHK("drive value", 1'b0, sda_out)
      $display("t_reset done");
   endtask : t_reset
   task automatic t_address;
      logic a;
      u_irqm_master.start();
      u_irqm_master.wbyte({irqm_pkg::ADDR_VARIANT_B, 1'b0}, a);
      `CHK("foreign addr ack", 1'b0, a)
      u_irqm_master.stop();
      `CHK("busy after stop", 1'b0, busy)
      $display("t_address done");
   endtask : t_address
   task automatic t_mask_rw;
      wr(8'h08, '{8'hff}, 1'b1);
      `CHK("mask write", 8'hef, mask)
      rd(8'h08, '{8'hef});
      wr(8'h09, '{8'h55}, 1'b0);
      `CHK("mask kept", 8'hef, mask)
      $display("t_mask_rw done");
   endtask : t_mask_rw
   task automatic t_burst;
      wq.delete();
      wr(8'h06, '{8'h11, 8'h22, 8'h5a}, 1'b1);
      wr(8'h00, '{8'h01, 8'h02}, 1'b1);
      `CHK("write count", 4, wq.size())
      `CHK("burst 0", 16'h0611, wq[0])
      `CHK("burst 1", 16'h0722, wq[1])
      `CHK("burst mask", 8'h4a, mask)
      `CHK("zero hold 0", 16'h0001, wq[2])
      `CHK("zero hold 1", 16'h0002, wq[3])
      rd(8'h07, '{8'h00, 8'h4a});
      $display("t_burst done");
   endtask : t_burst
   task automatic t_flags;
      for (int b = 0; b < 8; b++) begin
         wr(8'h08, '{8'h01 << b}, 1'b1);
         @(posedge clk);
         #1;
         fl_acc = 8'h00;
         status = 8'hff;
         repeat (4) @(posedge clk);
         #1;
         `CHK("flag gate", (8'h01 << b) & 8'hef, fl_acc)
         status = 8'h00;
      end
      $display("t_flags done");
   endtask : t_flags
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial begin
      #3200000;
      mismatches++;
      end_sim();
   end
   initial begin
      #5;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_address();
      t_mask_rw();
      t_burst();
      t_flags();
      end_sim();
   end
endmodule : irqm_regport_tb_top
`default_nettype wire
